// ### omm_pkg.sv
// constants for the output gating and divider margining configuration block
// assumes an 8-bit register address space and 8-bit register data
package omm_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // output counts
  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned NUM_STAT = 2;
  localparam int unsigned NUM_DIV  = 6;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CHANNEL_GATE_CTRL_OFS         = 8'h16;
  localparam logic [ADDR_W-1:0] STATUS_PIN_GATE_CTRL_OFS      = 8'h17;
  localparam logic [ADDR_W-1:0] DIVIDER_MARGIN_DELAY_CTRL_OFS = 8'h18;

  // reset values of the stored fields
  localparam logic [NUM_CH-1:0]   CHAN_GATE_RST = 8'hFF;
  localparam logic [NUM_STAT-1:0] STAT_GATE_RST = 2'h2;
  localparam logic [NUM_DIV-1:0]  DIV_MARGIN_RST = 6'h00;

  // status pin bit positions
  localparam int unsigned STAT_PIN0_BIT = 0;
  localparam int unsigned STAT_PIN1_BIT = 1;

  // divider margining: only divide values above this threshold may margin
  localparam int unsigned     DIV_VAL_W     = 8;
  localparam logic [DIV_VAL_W-1:0] DIV_MARGIN_MIN = 8'h08;

  // gated drive level codes
  localparam int unsigned LVL_W = 2;
  typedef logic [LVL_W-1:0] omm_lvl_t;
  localparam omm_lvl_t LVL_BYPASS    = 2'h0;
  localparam omm_lvl_t LVL_POWERDOWN = 2'h1;
  localparam omm_lvl_t LVL_FORCE_HI  = 2'h2;
  localparam omm_lvl_t LVL_RAIL_GND  = 2'h3;

  // first channel index and first divider index at which one divider serves a single channel
  localparam int unsigned FIRST_SINGLE_CH  = 4;
  localparam int unsigned FIRST_SINGLE_DIV = 2;

endpackage

// ### omm_gate_sync.sv
// one output's gate state, moved only on that output's own period boundary
// assumes edge_i is a one-cycle pulse marking a safe boundary of the output clock
`timescale 1ns/10ps
`default_nettype none
module omm_gate_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // request side
  input  wire logic             edge_i,
  input  wire logic [WIDTH-1:0] req_i,
  // gated state
  output logic      [WIDTH-1:0] state_o
);
  import omm_pkg::*;

  logic [WIDTH-1:0] state_q;

  // sampling only at the boundary keeps a running pulse from being cut short
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= '0;
    end
    else if (edge_i)
    begin
      state_q <= req_i;
    end
  end

  assign state_o = state_q;

  // a clear forced by reset is not a boundary move, so the first cycle after it is left out
  chk_gate_on_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!$stable(state_q) && $past(rst_n_i)) |-> $past(edge_i))
    else $error("gate state moved away from an output boundary");

endmodule
`default_nettype wire

// ### omm_ctrl.sv
// gating of outputs and status pins on an invalid reference, and divider margining enables
// assumes src_invalid_i and all boundary pulses are synchronous to clk_i
//
// Behaviour
// - A channel whose gating bit is 1 is disabled whenever the selected source is invalid, unless its level code is 0 (bypass).
// - A channel whose gating bit is 0 keeps running whatever the source validity.
// - The eight channel gating bits are read/write at the channel index, reset to 1, stored.
// - Status pin 1 is gated on an invalid source only as a clock output with its bit at 1.
// - A status pin not set up as a clock ignores its gating bit and keeps running.
// - Status pin 0 uses bit 0 alike; bit 0 resets to 0, bit 1 to 1, bits 7:2 are reserved.
// - A margin enable permits glitch-free coarse margining only for divide values above 8.
// - Margin bit 0 serves channels 0-1, bit 1 channels 2-3, bits 2-5 channels 4-7; reset 0.
// - A muted output drives its level code: 0 bypasses, 1 powers down, 2 forces high.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module omm_ctrl (
  // clock and reset
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_n_i,
  // register port
  input  wire logic [omm_pkg::ADDR_W-1:0]                addr_i,
  input  wire logic [omm_pkg::DATA_W-1:0]                wdata_i,
  input  wire logic                                      wr_i,
  input  wire logic                                      rd_i,
  output logic      [omm_pkg::DATA_W-1:0]                rdata_o,
  // non-volatile image load and stored values
  input  wire logic                                      nv_load_i,
  input  wire logic [omm_pkg::NUM_CH-1:0]                nv_chan_gate_i,
  input  wire logic [omm_pkg::NUM_STAT-1:0]              nv_stat_gate_i,
  input  wire logic [omm_pkg::NUM_DIV-1:0]               nv_div_margin_i,
  output logic      [omm_pkg::NUM_CH-1:0]                nv_chan_gate_o,
  output logic      [omm_pkg::NUM_STAT-1:0]              nv_stat_gate_o,
  output logic      [omm_pkg::NUM_DIV-1:0]               nv_div_margin_o,
  // reference detection
  input  wire logic                                      src_invalid_i,
  // output channels
  input  wire logic [omm_pkg::NUM_CH-1:0]                chan_edge_i,
  input  wire logic [omm_pkg::NUM_CH*omm_pkg::LVL_W-1:0] chan_gated_drive_level_i,
  output logic      [omm_pkg::NUM_CH-1:0]                chan_mute_o,
  output logic      [omm_pkg::NUM_CH*omm_pkg::LVL_W-1:0] chan_drive_lvl_o,
  // status pins
  input  wire logic [omm_pkg::NUM_STAT-1:0]              stat_edge_i,
  input  wire logic [omm_pkg::NUM_STAT-1:0]              stat_is_clk_i,
  output logic      [omm_pkg::NUM_STAT-1:0]              stat_mute_o,
  // output dividers
  input  wire logic [omm_pkg::NUM_DIV*omm_pkg::DIV_VAL_W-1:0] div_val_i,
  output logic      [omm_pkg::NUM_DIV-1:0]               div_margin_o,
  output logic      [omm_pkg::NUM_CH-1:0]                chan_margin_o
);
  import omm_pkg::*;

  // divider index that serves a given channel
  function automatic int unsigned chan_to_div(input int unsigned ch);
    if (ch < FIRST_SINGLE_CH)
      chan_to_div = ch / 2;
    else
      chan_to_div = ch - FIRST_SINGLE_CH + FIRST_SINGLE_DIV;
  endfunction

  logic [NUM_CH-1:0]        chan_gate_q;
  logic [NUM_STAT-1:0]      stat_gate_q;
  logic [NUM_DIV-1:0]       div_margin_q;
  logic [DATA_W-1:0]        rdata_q;
  logic [NUM_CH-1:0]        chan_req;
  logic [NUM_STAT-1:0]      stat_req;
  logic [NUM_DIV-1:0]       div_gt_min;
  logic [NUM_DIV-1:0]       div_ok_q;
  logic [NUM_CH-1:0]        chan_ok_q;
  logic                     wr_chan;
  logic                     wr_stat;
  logic                     wr_div;

  assign wr_chan = wr_i && (addr_i == CHANNEL_GATE_CTRL_OFS);
  assign wr_stat = wr_i && (addr_i == STATUS_PIN_GATE_CTRL_OFS);
  assign wr_div  = wr_i && (addr_i == DIVIDER_MARGIN_DELAY_CTRL_OFS);

  // channel gating bits; a software write wins over an image load in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      chan_gate_q <= CHAN_GATE_RST;
    end
    else if (wr_chan)
    begin
      chan_gate_q <= wdata_i[NUM_CH-1:0];
    end
    else if (nv_load_i)
    begin
      chan_gate_q <= nv_chan_gate_i;
    end
  end

  // status pin gating bits; the reserved upper bits are never stored
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      stat_gate_q <= STAT_GATE_RST;
    end
    else if (wr_stat)
    begin
      stat_gate_q <= wdata_i[NUM_STAT-1:0];
    end
    else if (nv_load_i)
    begin
      stat_gate_q <= nv_stat_gate_i;
    end
  end

  // divider margin enables
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_margin_q <= DIV_MARGIN_RST;
    end
    else if (wr_div)
    begin
      div_margin_q <= wdata_i[NUM_DIV-1:0];
    end
    else if (nv_load_i)
    begin
      div_margin_q <= nv_div_margin_i;
    end
  end

  // read data stand one cycle after the strobe; unmapped and reserved bits read zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= '0;
    end
    else if (rd_i)
    begin
      case (addr_i)
        CHANNEL_GATE_CTRL_OFS:         rdata_q <= chan_gate_q;
        STATUS_PIN_GATE_CTRL_OFS:      rdata_q <= {{(DATA_W-NUM_STAT){1'b0}}, stat_gate_q};
        DIVIDER_MARGIN_DELAY_CTRL_OFS: rdata_q <= {{(DATA_W-NUM_DIV){1'b0}}, div_margin_q};
        default:                       rdata_q <= '0;
      endcase
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  assign rdata_o         = rdata_q;
  assign nv_chan_gate_o  = chan_gate_q;
  assign nv_stat_gate_o  = stat_gate_q;
  assign nv_div_margin_o = div_margin_q;

  // per channel: a bypass level code turns the mute off even with the gating bit set
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++)
    begin : g_chan
      logic [LVL_W-1:0] lvl;
      logic [LVL_W-1:0] code;
      logic [LVL_W-1:0] code_q;
      assign lvl  = chan_gated_drive_level_i[gc*LVL_W +: LVL_W];
      assign code = (src_invalid_i && chan_gate_q[gc]) ? lvl : LVL_BYPASS;
      assign chan_req[gc] = (code != LVL_BYPASS);
      omm_gate_sync #(
        .WIDTH   (LVL_W)
      ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .edge_i  (chan_edge_i[gc]),
        .req_i   (code),
        .state_o (code_q)
      );
      assign chan_drive_lvl_o[gc*LVL_W +: LVL_W] = code_q;
      assign chan_mute_o[gc] = (code_q != LVL_BYPASS);
    end
  endgenerate

  // status pins gate only while they carry a clock
  genvar gs;
  generate
    for (gs = 0; gs < NUM_STAT; gs++)
    begin : g_stat
      assign stat_req[gs] = src_invalid_i && stat_is_clk_i[gs] && stat_gate_q[gs];
      omm_gate_sync #(
        .WIDTH   (1)
      ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .edge_i  (stat_edge_i[gs]),
        .req_i   (stat_req[gs]),
        .state_o (stat_mute_o[gs])
      );
    end
  endgenerate

  // margining is only glitch-free above the minimum divide value
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DIV; gd++)
    begin : g_div
      assign div_gt_min[gd] = div_val_i[gd*DIV_VAL_W +: DIV_VAL_W] > DIV_MARGIN_MIN;
    end
  endgenerate

  // registered margin permits per divider and per channel
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_ok_q  <= '0;
      chan_ok_q <= '0;
    end
    else
    begin
      div_ok_q <= div_margin_q & div_gt_min;
      for (int unsigned c = 0; c < NUM_CH; c++)
      begin
        chan_ok_q[c] <= div_margin_q[chan_to_div(c)] && div_gt_min[chan_to_div(c)];
      end
    end
  end

  assign div_margin_o  = div_ok_q;
  assign chan_margin_o = chan_ok_q;

  // checks; attempts launched on a reset edge are skipped, since boundary pulses are ignored there
  chk_chan_gate_apply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rst_n_i |=> ((chan_mute_o & $past(chan_edge_i & chan_req))
                 == $past(chan_edge_i & chan_req)))
    else $error("gated channel not muted at its boundary");
  chk_chan_gate_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rst_n_i |=> ((chan_mute_o & ~$past(chan_mute_o) & ~$past(chan_gate_q)) == '0))
    else $error("channel muted with gating bit clear");
  chk_chan_reg_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && wr_chan) |=> (chan_gate_q == $past(wdata_i)))
    else $error("channel gating write lost");
  chk_chan_reg_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (chan_gate_q == CHAN_GATE_RST) && (stat_gate_q == STAT_GATE_RST))
    else $error("gating bits wrong after reset");
  chk_stat_gate_apply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && stat_edge_i[STAT_PIN1_BIT] && src_invalid_i && stat_is_clk_i[STAT_PIN1_BIT]
     && stat_gate_q[STAT_PIN1_BIT]) |=> stat_mute_o[STAT_PIN1_BIT])
    else $error("status pin 1 not gated");
  chk_stat_not_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rst_n_i |=> ((stat_mute_o & ~$past(stat_mute_o) & ~$past(stat_is_clk_i)) == '0))
    else $error("non-clock status pin gated");
  chk_stat_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && rd_i && addr_i == STATUS_PIN_GATE_CTRL_OFS) |=>
      (rdata_o == {{(DATA_W-NUM_STAT){1'b0}}, $past(stat_gate_q)}))
    else $error("status gating read wrong");
  chk_margin_min_div: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rst_n_i |=> ((div_margin_o & ~$past(div_gt_min)) == '0))
    else $error("margin permitted at low divide value");
  chk_margin_pairing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rst_n_i |=> (chan_margin_o[0] == div_margin_o[0]) && (chan_margin_o[1] == div_margin_o[0])
             && (chan_margin_o[3] == div_margin_o[1]) && (chan_margin_o[7] == div_margin_o[5]))
    else $error("margin enable mapped to wrong channel");
  chk_bypass_no_mute: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (chan_edge_i[0] && chan_gated_drive_level_i[LVL_W-1:0] == LVL_BYPASS)
      |=> !chan_mute_o[0])
    else $error("bypass level code still muted");

  cov_chan_muted: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !chan_mute_o[5] ##1 chan_mute_o[5] ##[1:20] !chan_mute_o[5]);
  cov_stat_muted: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(stat_mute_o[STAT_PIN0_BIT]));
  cov_margin_on: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(div_margin_o[2]));

endmodule
`default_nettype wire

// ### output_mute_and_margin_ctrl_bench.sv
// self-checking bench for omm_ctrl: random traffic compared against a cycle model
// assumes one 125 MHz clock and the register port of the design
`timescale 1ns/10ps
`default_nettype none
module output_mute_and_margin_ctrl_bench;
  import omm_pkg::*;
  // design ports
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = '0;
  logic [7:0]  wdata_i = '0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        nv_load_i = 1'b0;
  logic [7:0]  nv_chan_gate_i = '0;
  logic [1:0]  nv_stat_gate_i = '0;
  logic [5:0]  nv_div_margin_i = '0;
  logic [7:0]  nv_chan_gate_o;
  logic [1:0]  nv_stat_gate_o;
  logic [5:0]  nv_div_margin_o;
  logic        src_invalid_i = 1'b0;
  logic [7:0]  chan_edge_i = '0;
  logic [15:0] lvl_i = '0;
  logic [7:0]  chan_mute_o;
  logic [15:0] chan_drive_lvl_o;
  logic [1:0]  stat_edge_i = '0;
  logic [1:0]  stat_is_clk_i = '0;
  logic [1:0]  stat_mute_o;
  logic [47:0] div_val_i = '0;
  logic [5:0]  div_margin_o;
  logic [7:0]  chan_margin_o;
  // expected state, kept the way the rules describe it
  logic [7:0]  m_cg, m_rd, m_cm, m_ch;
  logic [1:0]  m_sg, m_sm;
  logic [5:0]  m_dm, m_dv;
  logic [15:0] m_lv;
  logic        chk_on = 1'b0;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;

  omm_ctrl u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .nv_load_i,
    .nv_chan_gate_i, .nv_stat_gate_i, .nv_div_margin_i, .nv_chan_gate_o, .nv_stat_gate_o,
    .nv_div_margin_o, .src_invalid_i, .chan_edge_i, .chan_gated_drive_level_i(lvl_i),
    .chan_mute_o, .chan_drive_lvl_o, .stat_edge_i, .stat_is_clk_i, .stat_mute_o,
    .div_val_i, .div_margin_o, .chan_margin_o);

  // 8 ns period
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  // reserved bits read back as zero, unmapped places read zero
  function automatic logic [7:0] reg_val(input logic [7:0] a);
    case (a)
      8'h16:   reg_val = m_cg;
      8'h17:   reg_val = {6'h00, m_sg};
      8'h18:   reg_val = {2'h0, m_dm};
      default: reg_val = 8'h00;
    endcase
  endfunction

  // cycle model; gates move only on their own boundary pulse
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      m_cg <= 8'hFF;
      m_sg <= 2'h2;
      m_dm <= 6'h00;
      m_rd <= 8'h00;
      m_cm <= 8'h00;
      m_lv <= 16'h0000;
      m_sm <= 2'h0;
      m_dv <= 6'h00;
      m_ch <= 8'h00;
    end
    else
    begin
      m_cg <= (wr_i && addr_i == 8'h16) ? wdata_i : nv_load_i ? nv_chan_gate_i : m_cg;
      m_sg <= (wr_i && addr_i == 8'h17) ? wdata_i[1:0] : nv_load_i ? nv_stat_gate_i : m_sg;
      m_dm <= (wr_i && addr_i == 8'h18) ? wdata_i[5:0] : nv_load_i ? nv_div_margin_i : m_dm;
      m_rd <= rd_i ? reg_val(addr_i) : 8'h00;
      for (int n = 0; n < 8; n++)
      begin
        if (chan_edge_i[n])
        begin
          m_cm[n] <= m_cg[n] & src_invalid_i & (lvl_i[2*n+:2] != 2'h0);
          m_lv[2*n+:2] <= (m_cg[n] & src_invalid_i) ? lvl_i[2*n+:2] : 2'h0;
        end
      end
      for (int k = 0; k < 2; k++)
      begin
        if (stat_edge_i[k])
          m_sm[k] <= m_sg[k] & src_invalid_i & stat_is_clk_i[k];
      end
      for (int k = 0; k < 6; k++)
        m_dv[k] <= m_dm[k] & (div_val_i[8*k+:8] > 8'h08);
      for (int n = 0; n < 8; n++)
      begin
        int d;
        d = (n < 4) ? n / 2 : n - 2;
        m_ch[n] <= m_dm[d] & (div_val_i[8*d+:8] > 8'h08);
      end
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // outputs are settled by the falling edge
  always @(negedge clk_i)
  begin
    if (chk_on)
    begin
      check(16'(rdata_o), 16'(m_rd));
      check(16'(nv_chan_gate_o), 16'(m_cg));
      check(16'(nv_stat_gate_o), 16'(m_sg));
      check(16'(nv_div_margin_o), 16'(m_dm));
      check(16'(chan_mute_o), 16'(m_cm));
      check(chan_drive_lvl_o, m_lv);
      check(16'(stat_mute_o), 16'(m_sm));
      check(16'(div_margin_o), 16'(m_dv));
      check(16'(chan_margin_o), 16'(m_ch));
    end
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      final_report();
    end
  end

  // one register access; boundary pulses are quiet, an image load may coincide and must lose
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    chan_edge_i <= 8'h00;
    stat_edge_i <= 2'h0;
    nv_load_i <= 1'($urandom);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask

  // divide values 8 and 9 come often, as the threshold sits between them
  task automatic traffic(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      src_invalid_i <= 1'($urandom);
      chan_edge_i <= 8'($urandom);
      stat_edge_i <= 2'($urandom);
      stat_is_clk_i <= 2'($urandom);
      lvl_i <= 16'($urandom);
      nv_load_i <= ($urandom % 8 == 0);
      nv_chan_gate_i <= 8'($urandom);
      nv_stat_gate_i <= 2'($urandom);
      nv_div_margin_i <= 6'($urandom);
      for (int k = 0; k < 6; k++)
        div_val_i[8*k+:8] <= ($urandom % 2) ? 8'h08 + 8'($urandom % 2) : 8'($urandom);
    end
  endtask

  task automatic read_all();
    for (int a = 8'h15; a <= 8'h19; a++)
      bus(1'b0, 8'(a), 8'h00);
  endtask

  initial
  begin
    void'($urandom(32'hF534));
    @(posedge clk_i);
    chk_on <= 1'b1;
    repeat (19) @(posedge clk_i);
    rst_n_i <= 1'b1;
    read_all();
    bus(1'b1, 8'h17, 8'hFF);
    bus(1'b1, 8'h18, 8'hFF);
    bus(1'b1, 8'h30, 8'hA5);
    read_all();
    repeat (40)
    begin
      bus(1'b1, 8'h16, 8'($urandom));
      bus(1'b1, 8'h17, 8'($urandom));
      bus(1'b1, 8'h18, 8'($urandom));
      traffic(20);
      read_all();
    end
    // reset again in mid-run
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    traffic(3);
    rst_n_i <= 1'b1;
    read_all();
    traffic(20);
    final_report();
  end
endmodule
`default_nettype wire
